// [hw/pio_pkg.sv]
// Constants for the port 2 and 3 output latch and port 1 to 3 driver mode block
package pio_pkg;
    // ------------------------------------------------------------------
    // Register addresses on the special function register bus
    // ------------------------------------------------------------------
    localparam logic [7:0] PIO_ADDR_P2_LATCH = 8'ha0;
    localparam logic [7:0] PIO_ADDR_P1_MODE  = 8'ha5;
    // Addresses below are not fixed by the device text
    localparam logic [7:0] PIO_ADDR_P2_MODE  = 8'ha6;
    localparam logic [7:0] PIO_ADDR_P3_LATCH = 8'hb0;
    localparam logic [7:0] PIO_ADDR_P3_MODE  = 8'ha7;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] PIO_RST_LATCH = 8'hff;
    localparam logic [7:0] PIO_RST_MODE  = 8'h00;

    // ------------------------------------------------------------------
    // Driver mode encoding
    // ------------------------------------------------------------------
    localparam logic PIO_MODE_OPEN_DRAIN = 1'b0;
    localparam logic PIO_MODE_PUSH_PULL  = 1'b1;
endpackage : pio_pkg

// [hw/pio_ports.sv]
// Port 2 and 3 output latches, port 1 to 3 driver modes, port 2 and 3 pin readback
//
// Overview of operation
// - Each driver mode register holds eight bits, bit n for pin n.
// - A mode bit of 0 gives open-drain, 1 gives push-pull.
// - A latch bit of 0 drives the pin low, 1 drives it high per mode.
// - Latch 1 with mode 0 leaves the pin undriven.
// - Reading a port data register returns the synchronised pin levels.
// - Latch values reach only pins the crossbar leaves to general I/O.
// - Two-wire serial pins and mode 0 receive pins are forced open-drain.
// - The memory interface may drive port 3 with its address/data byte.
// - A read-modify-write read returns the latch instead of the pins.
`timescale 1ns/1ps
module pio_ports
    import pio_pkg::*;
(
    // Clock and reset
    input  wire logic       sys_clk_in,
    input  wire logic       rstn_in,
    // Special function register bus
    input  wire logic [7:0] sfr_addr_in,
    input  wire logic [7:0] sfr_wdata_in,
    input  wire logic       sfr_wr_in,
    input  wire logic       sfr_rd_in,
    input  wire logic       sfr_rmw_in,
    input  wire logic       sfr_bit_wr_in,
    input  wire logic [2:0] sfr_bit_sel_in,
    output logic      [7:0] sfr_rdata_out,
    // Crossbar: 1 marks a pin taken by a peripheral
    input  wire logic [7:0] p1_periph_sel_in,
    input  wire logic [7:0] p2_periph_sel_in,
    input  wire logic [7:0] p3_periph_sel_in,
    input  wire logic [7:0] p1_periph_out_in,
    input  wire logic [7:0] p2_periph_out_in,
    input  wire logic [7:0] p3_periph_out_in,
    // Pins forced open-drain (two-wire serial, mode 0 receive)
    input  wire logic [7:0] p1_force_od_in,
    input  wire logic [7:0] p2_force_od_in,
    input  wire logic [7:0] p3_force_od_in,
    // Port 1 output data from the system
    input  wire logic [7:0] p1_latch_in,
    // External memory interface on port 3
    input  wire logic       mem_p3_drive_in,
    input  wire logic       mem_p3_read_in,
    input  wire logic [7:0] mem_p3_data_in,
    // Pins
    input  wire logic [7:0] p1_pin_in,
    input  wire logic [7:0] p2_pin_in,
    input  wire logic [7:0] p3_pin_in,
    output logic      [7:0] p1_pin_out,
    output logic      [7:0] p2_pin_out,
    output logic      [7:0] p3_pin_out,
    output logic      [7:0] p1_pin_oe_out,
    output logic      [7:0] p2_pin_oe_out,
    output logic      [7:0] p3_pin_oe_out
);
    // ------------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------------
    logic [7:0] port2_output_latch;
    logic [7:0] port3_output_latch;
    logic [7:0] port1_driver_mode;
    logic [7:0] port2_driver_mode;
    logic [7:0] port3_driver_mode;

    // Byte write or single-bit update of a latch
    function automatic logic [7:0] pio_latch_upd(
        input logic [7:0] cur,
        input logic [7:0] wdata,
        input logic       bit_wr,
        input logic [2:0] sel
    );
        logic [7:0] res;
        res = cur;
        if (bit_wr) begin
            res[sel] = wdata[0];
        end else begin
            res = wdata;
        end
        return res;
    endfunction : pio_latch_upd

    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            port2_output_latch <= PIO_RST_LATCH;
            port3_output_latch <= PIO_RST_LATCH;
        end else if (sfr_wr_in) begin
            if (sfr_addr_in == PIO_ADDR_P2_LATCH) begin
                port2_output_latch <= pio_latch_upd(port2_output_latch,
                    sfr_wdata_in, sfr_bit_wr_in, sfr_bit_sel_in);
            end else if (sfr_addr_in == PIO_ADDR_P3_LATCH) begin
                port3_output_latch <= pio_latch_upd(port3_output_latch,
                    sfr_wdata_in, sfr_bit_wr_in, sfr_bit_sel_in);
            end
        end
    end

    // Mode registers are byte-wide only
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            port1_driver_mode <= PIO_RST_MODE;
            port2_driver_mode <= PIO_RST_MODE;
            port3_driver_mode <= PIO_RST_MODE;
        end else if (sfr_wr_in && !sfr_bit_wr_in) begin
            if (sfr_addr_in == PIO_ADDR_P1_MODE) begin
                port1_driver_mode <= sfr_wdata_in;
            end else if (sfr_addr_in == PIO_ADDR_P2_MODE) begin
                port2_driver_mode <= sfr_wdata_in;
            end else if (sfr_addr_in == PIO_ADDR_P3_MODE) begin
                port3_driver_mode <= sfr_wdata_in;
            end
        end
    end

    // ------------------------------------------------------------------
    // Pin input synchronisers
    // ------------------------------------------------------------------
    logic [7:0] p2_meta;
    logic [7:0] p3_meta;
    logic [7:0] p2_sync;
    logic [7:0] p3_sync;

    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            p2_meta <= 8'h00;
            p3_meta <= 8'h00;
            p2_sync <= 8'h00;
            p3_sync <= 8'h00;
        end else begin
            p2_meta <= p2_pin_in;
            p3_meta <= p3_pin_in;
            p2_sync <= p2_meta;
            p3_sync <= p3_meta;
        end
    end

    // ------------------------------------------------------------------
    // Read data, registered one cycle after the read strobe
    // ------------------------------------------------------------------
    logic [7:0] next_rdata;

    always_comb begin
        next_rdata = 8'h00;
        if (sfr_addr_in == PIO_ADDR_P2_LATCH) begin
            next_rdata = sfr_rmw_in ? port2_output_latch : p2_sync;
        end else if (sfr_addr_in == PIO_ADDR_P3_LATCH) begin
            next_rdata = sfr_rmw_in ? port3_output_latch : p3_sync;
        end else if (sfr_addr_in == PIO_ADDR_P1_MODE) begin
            next_rdata = port1_driver_mode;
        end else if (sfr_addr_in == PIO_ADDR_P2_MODE) begin
            next_rdata = port2_driver_mode;
        end else if (sfr_addr_in == PIO_ADDR_P3_MODE) begin
            next_rdata = port3_driver_mode;
        end
    end

    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            sfr_rdata_out <= 8'h00;
        end else if (sfr_rd_in) begin
            sfr_rdata_out <= next_rdata;
        end
    end

    // ------------------------------------------------------------------
    // Pin drivers
    // ------------------------------------------------------------------
    // Pin level only matters when enabled; open-drain drives low only
    logic [7:0] p1_val;
    logic [7:0] p2_val;
    logic [7:0] p3_val;
    logic [7:0] p1_pp;
    logic [7:0] p2_pp;
    logic [7:0] p3_pp;
    logic [7:0] next_p3_out;
    logic [7:0] next_p3_oe;

    always_comb begin
        p1_val = (p1_periph_sel_in & p1_periph_out_in)
               | (~p1_periph_sel_in & p1_latch_in);
        p2_val = (p2_periph_sel_in & p2_periph_out_in)
               | (~p2_periph_sel_in & port2_output_latch);
        p3_val = (p3_periph_sel_in & p3_periph_out_in)
               | (~p3_periph_sel_in & port3_output_latch);
        p1_pp = port1_driver_mode & ~p1_force_od_in;
        p2_pp = port2_driver_mode & ~p2_force_od_in;
        p3_pp = port3_driver_mode & ~p3_force_od_in;
        next_p3_out = p3_val;
        next_p3_oe  = ~p3_val | p3_pp;
        if (mem_p3_drive_in) begin
            // Memory read turns the data bus drivers off
            next_p3_out = mem_p3_data_in;
            next_p3_oe  = mem_p3_read_in ? 8'h00 : (~mem_p3_data_in | p3_pp);
        end
    end

    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            p1_pin_out    <= 8'h00;
            p2_pin_out    <= 8'h00;
            p3_pin_out    <= 8'h00;
            p1_pin_oe_out <= 8'h00;
            p2_pin_oe_out <= 8'h00;
            p3_pin_oe_out <= 8'h00;
        end else begin
            p1_pin_out    <= p1_val;
            p2_pin_out    <= p2_val;
            p3_pin_out    <= next_p3_out;
            p1_pin_oe_out <= ~p1_val | p1_pp;
            p2_pin_oe_out <= ~p2_val | p2_pp;
            p3_pin_oe_out <= next_p3_oe;
        end
    end
endmodule : pio_ports

// [verif/pio_pin_model.sv]
// Pin level model of the board circuitry on one port
`timescale 1ns/1ps
module pio_pin_model (
    input  wire logic [7:0] oe_in,
    input  wire logic [7:0] val_in,
    input  wire logic [7:0] pull_low_in,
    output logic      [7:0] pin_out
);
    // A released pin sits on the weak pullup unless pulled low outside
    assign pin_out = (oe_in & val_in) | (~oe_in & ~pull_low_in);
endmodule : pio_pin_model

// [verif/pio_ports_sva.sv]
// Checker for the port block pin drivers and register reads
`timescale 1ns/1ps
module pio_ports_sva import pio_pkg::*; (
    input wire logic sys_clk_in, rstn_in, sfr_rd_in, sfr_rmw_in,
    input wire logic mem_p3_drive_in, mem_p3_read_in,
    input wire logic [7:0] sfr_addr_in, sfr_rdata_out, p1_latch_in,
    input wire logic [7:0] p1_periph_sel_in, p1_pin_out, p1_pin_oe_out,
    input wire logic [7:0] p2_periph_sel_in, p2_periph_out_in, p2_pin_in,
    input wire logic [7:0] p2_force_od_in, p2_pin_out, p2_pin_oe_out,
    input wire logic [7:0] p3_periph_sel_in, mem_p3_data_in,
    input wire logic [7:0] p3_pin_out, p3_pin_oe_out
);
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!rstn_in);
    logic mapped;
    assign mapped = sfr_addr_in inside {PIO_ADDR_P2_LATCH, PIO_ADDR_P1_MODE,
        PIO_ADDR_P2_MODE, PIO_ADDR_P3_LATCH, PIO_ADDR_P3_MODE};
    a_low_driven: assert property ($past(rstn_in) |->
        (~p2_pin_out & ~p2_pin_oe_out) == 8'h00) else $error("low undriven");
    a_forced_od: assert property ($past(rstn_in) |->
        ($past(p2_force_od_in) & p2_pin_out & p2_pin_oe_out) == 8'h00)
        else $error("forced pin driven high");
    a_crossbar_val: assert property ($past(rstn_in) |->
        ((p2_pin_out ^ $past(p2_periph_out_in)) & $past(p2_periph_sel_in)
        & p2_pin_oe_out) == 8'h00) else $error("peripheral value lost");
    a_p1_latch: assert property ($past(rstn_in) |->
        ((p1_pin_out ^ $past(p1_latch_in)) & ~$past(p1_periph_sel_in)
        & p1_pin_oe_out) == 8'h00) else $error("port1 value wrong");
    a_mem_data: assert property ($past(mem_p3_drive_in)
        && !$past(mem_p3_read_in) && $past(p3_periph_sel_in) == 8'h00
        && $past(rstn_in) |-> p3_pin_out == $past(mem_p3_data_in))
        else $error("mem data");
    a_mem_read_off: assert property ($past(mem_p3_drive_in)
        && $past(mem_p3_read_in) && $past(rstn_in)
        |-> p3_pin_oe_out == 8'h00) else $error("mem rd");
    a_pin_readback: assert property ($stable(p2_pin_in)[*4] ##0
        ($past(rstn_in, 4) && sfr_rd_in && !sfr_rmw_in
        && sfr_addr_in == PIO_ADDR_P2_LATCH)
        |=> sfr_rdata_out == $past(p2_pin_in, 2)) else $error("readback");
    a_unmapped_zero: assert property (sfr_rd_in && !mapped
        |=> sfr_rdata_out == 8'h00) else $error("unmapped read");
    a_rdata_hold: assert property (!sfr_rd_in |=> $stable(sfr_rdata_out))
        else $error("read data moved");
    c_mem_read: cover property (mem_p3_drive_in && mem_p3_read_in);
    c_forced: cover property (p2_force_od_in != 8'h00);
    c_rmw_read: cover property (sfr_rd_in && sfr_rmw_in);
endmodule : pio_ports_sva

// [verif/pio_ports_bench.sv]
// Bench for the port block: registers, pins, crossbar and memory drive
`timescale 1ns/1ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin err_total++; \
    $display("wrong value t=%0t got %h exp %h", $time, a, e); end end
module pio_ports_bench import pio_pkg::*;;
    logic sys_clk_in = 0, rstn_in = 0, sfr_wr_in = 0, sfr_rd_in = 0;
    logic sfr_rmw_in = 0, sfr_bit_wr_in = 0, mem_p3_drive_in = 0;
    logic mem_p3_read_in = 0;
    logic [2:0] sfr_bit_sel_in = 0;
    logic [7:0] sfr_addr_in = 0, sfr_wdata_in = 0, p1_latch_in = 0, ext2 = 0;
    logic [7:0] p1_periph_sel_in = 0, p2_periph_sel_in = 0, mem_p3_data_in = 0;
    logic [7:0] p3_periph_sel_in = 0, p1_periph_out_in = 0, p2_force_od_in = 0;
    logic [7:0] p2_periph_out_in = 0, p3_periph_out_in = 0, p1_force_od_in = 0;
    logic [7:0] p3_force_od_in = 0, sfr_rdata_out, p1_pin_in, p2_pin_in;
    logic [7:0] p3_pin_in, p1_pin_out, p2_pin_out, p3_pin_out, p1_pin_oe_out;
    logic [7:0] p2_pin_oe_out, p3_pin_oe_out, seed = 8'h46, r, lat, md, fo, v, o;
    logic [7:0] ra[5] = '{PIO_ADDR_P2_LATCH, PIO_ADDR_P1_MODE,
        PIO_ADDR_P2_MODE, PIO_ADDR_P3_LATCH, PIO_ADDR_P3_MODE};
    int err_total = 0, total_checks = 0;
    always #20 sys_clk_in = ~sys_clk_in;
    pio_ports dut (.*);
    pio_pin_model m2 (.oe_in(p2_pin_oe_out), .val_in(p2_pin_out),
        .pull_low_in(ext2), .pin_out(p2_pin_in));
    assign p1_pin_in = p1_pin_out | ~p1_pin_oe_out;
    assign p3_pin_in = p3_pin_out | ~p3_pin_oe_out;
    function automatic logic [7:0] rnd();
        seed = {seed[6:0], seed[7] ^ seed[5] ^ seed[4] ^ seed[3]};
        return seed;
    endfunction : rnd
    task automatic wr(input logic [7:0] a, d, input logic b = 0,
                      input logic [2:0] k = 0);
        sfr_addr_in <= a; sfr_wdata_in <= d; sfr_bit_wr_in <= b;
        sfr_bit_sel_in <= k; sfr_wr_in <= 1;
        @(posedge sys_clk_in) sfr_wr_in <= 0;
        @(posedge sys_clk_in);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic m);
        sfr_addr_in <= a; sfr_rmw_in <= m; sfr_rd_in <= 1;
        @(posedge sys_clk_in) sfr_rd_in <= 0;
        #1 r = sfr_rdata_out;
        @(posedge sys_clk_in);
    endtask : rd
    task automatic finish_test();
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : finish_test
    initial begin
        #(40 * 3000) err_total++;
        finish_test();
    end
    initial begin
        repeat (3) @(posedge sys_clk_in);
        rstn_in <= 1;
        @(posedge sys_clk_in);
        for (int i = 0; i < 5; i++) begin
            rd(ra[i], 1);
            `CHK(r, (i % 3 == 0) ? PIO_RST_LATCH : PIO_RST_MODE)
        end
        #1 `CHK(p2_pin_oe_out, 8'h00)
        @(posedge sys_clk_in);
        $display("test reset done");
        for (int i = 0; i < 16; i++) begin
            lat = rnd(); md = rnd(); fo = rnd(); v = rnd(); o = rnd();
            p2_force_od_in <= fo; p1_force_od_in <= fo; p1_latch_in <= lat;
            p2_periph_sel_in <= v; p2_periph_out_in <= o; ext2 <= rnd();
            wr(PIO_ADDR_P2_LATCH, lat); wr(PIO_ADDR_P2_MODE, md);
            wr(PIO_ADDR_P1_MODE, md);
            repeat (3) @(posedge sys_clk_in);
            v = (v & o) | (~v & lat); o = ~v | (md & ~fo);
            #1 `CHK(p2_pin_oe_out, o)
            `CHK(p2_pin_out & o, v & o)
            `CHK(p1_pin_oe_out, ~lat | (md & ~fo))
            @(posedge sys_clk_in);
            rd(PIO_ADDR_P2_LATCH, 0); `CHK(r, (o & v) | (~o & ~ext2))
            rd(PIO_ADDR_P2_LATCH, 1); `CHK(r, lat)
            rd(PIO_ADDR_P2_MODE, 0); `CHK(r, md)
        end
        for (int k = 0; k < 8; k++) begin
            lat[k] = ~lat[k];
            wr(PIO_ADDR_P2_LATCH, {7'h00, lat[k]}, 1, k[2:0]);
            rd(PIO_ADDR_P2_LATCH, 1); `CHK(r, lat)
        end
        wr(PIO_ADDR_P2_MODE, {7'h00, ~md[0]}, 1, 3'h0);
        rd(PIO_ADDR_P2_MODE, 0); `CHK(r, md)
        wr(8'h55, 8'h3c); rd(8'h55, 0); `CHK(r, 8'h00)
        $display("test registers done");
        wr(PIO_ADDR_P3_MODE, 8'hff);
        for (int i = 0; i < 4; i++) begin
            v = rnd(); mem_p3_data_in <= v; mem_p3_drive_in <= 1;
            mem_p3_read_in <= i[0];
            repeat (2) @(posedge sys_clk_in);
            #1 `CHK(p3_pin_oe_out, i[0] ? 8'h00 : 8'hff)
            if (!i[0]) `CHK(p3_pin_out, v)
            @(posedge sys_clk_in);
        end
        mem_p3_drive_in <= 0;
        $display("test memory done");
        // Port 3 latch, crossbar and forced open-drain, port 1 crossbar
        for (int i = 0; i < 8; i++) begin
            lat = rnd(); md = rnd(); fo = rnd(); v = rnd(); o = rnd();
            p3_force_od_in <= fo; p3_periph_sel_in <= v; p1_latch_in <= lat;
            p3_periph_out_in <= o; p1_periph_sel_in <= v;
            p1_periph_out_in <= o;
            wr(PIO_ADDR_P3_LATCH, lat); wr(PIO_ADDR_P3_MODE, md);
            repeat (2) @(posedge sys_clk_in);
            v = (v & o) | (~v & lat); o = ~v | (md & ~fo);
            #1 `CHK(p3_pin_oe_out, o)
            `CHK(p3_pin_out, v)
            `CHK(p1_pin_out, v)
            @(posedge sys_clk_in);
            rd(PIO_ADDR_P3_LATCH, 0); `CHK(r, (v & o) | ~o)
            rd(PIO_ADDR_P3_LATCH, 1); `CHK(r, lat)
        end
        $display("test port three done");
        // Reset in mid-run must bring the port 3 latch and port 3 mode back
        rstn_in <= 0;
        @(posedge sys_clk_in) rstn_in <= 1;
        @(posedge sys_clk_in);
        rd(PIO_ADDR_P3_LATCH, 1); `CHK(r, PIO_RST_LATCH)
        rd(PIO_ADDR_P3_MODE, 0); `CHK(r, PIO_RST_MODE)
        $display("test reset again done");
        finish_test();
    end
endmodule : pio_ports_bench
bind pio_ports pio_ports_sva chk (.*);
